// >>> hw/adc_ctrl.sv
// Purpose: Range select, scaling, clamping, open-circuit code, averaging, result words
// Assumes: Converter on the module clock, reading in span units (0 low end, 6000 high)
// Notes:   Switch inputs are pins and pass a three-stage agreement synchroniser
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl
    import adc_pkg::*;
#(
    parameter int unsigned POINT_CYC_P = adc_pkg::POINT_CYC
)
(
    input wire logic mclk, // Module clock, 10 MHz
    input wire logic rst, // Synchronous reset, high
    input wire logic [adc_pkg::SW_RANGE_BITS-1:0] range_sw, // Range switches, pins
    input wire logic avg_sw, // Averaging switch, pin
    input wire logic four_sw, // Input-count switch, pin
    input wire logic soft_en_sw, // Software range enable switch, pin
    input wire logic [adc_pkg::CH_NUM*adc_pkg::RNG_W-1:0] soft_range, // Per-input ranges
    input wire logic conv_done, // Converter result strobe
    input wire logic [adc_pkg::WORD_W-1:0] conv_raw, // Converter reading, span units
    output logic conv_start, // Start conversion pulse
    output logic [adc_pkg::CH_W-1:0] conv_ch, // Input being converted
    output logic [adc_pkg::RNG_W-1:0] conv_rng, // Range of that input
    output logic [adc_pkg::CH_NUM*adc_pkg::WORD_W-1:0] res_word, // Result words
    output logic [adc_pkg::CH_NUM-1:0] res_valid, // Word holds a result
    output logic res_upd, // Word update pulse
    output logic [adc_pkg::CH_W-1:0] res_idx, // Word index updated
    output logic four_mode, // Four-input mode active
    output logic range_bad // Last conversion had an invalid range code
);
    import adc_pkg::*;

    // Switch synchroniser
    logic [SW_NUM-1:0] sw_pin;
    logic [SW_NUM-1:0] s1_r, s2_r, s3_r, sw_r;
    logic [SW_NUM-1:0] sw_nxt;

    assign sw_pin = {soft_en_sw, four_sw, avg_sw, range_sw};

    genvar gi;
    generate
        for (gi = 0; gi < SW_NUM; gi++)
        begin : g_sync
            always_comb
            begin
                sw_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : sw_r[gi];
            end
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            sw_r <= '0;
        end
        else
        begin
            s1_r <= sw_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            sw_r <= sw_nxt;
        end
    end

    // Range per input: pair switches or per-input software value
    logic [RNG_W-1:0] rng_sel [CH_NUM];
    generate
        for (gi = 0; gi < CH_NUM; gi++)
        begin : g_rng
            assign rng_sel[gi] = sw_r[SW_SOFT] ? soft_range[gi*RNG_W +: RNG_W]
                                               : sw_r[(gi/2)*RNG_W +: RNG_W];
        end
    endgenerate

    // Sequencer and result state
    adc_state_type state_r, state_nxt;
    logic [TICK_W-1:0] tick_r, tick_nxt;
    logic [CH_W-1:0] ch_r, ch_nxt;
    logic start_r, start_nxt;
    logic [RNG_W-1:0] rng_r, rng_nxt;
    logic [WORD_W-1:0] samp_r, samp_nxt;
    logic open_r, open_nxt;
    logic bad_r, bad_nxt;
    logic [CH_NUM*WORD_W-1:0] word_r, word_nxt;
    logic [CH_NUM-1:0] valid_r, valid_nxt;
    logic upd_r, upd_nxt;
    logic [CH_W-1:0] idx_r, idx_nxt;
    logic four_r, four_nxt;
    logic signed [SUM_W-1:0] sum_r [CH_NUM];
    logic signed [SUM_W-1:0] sum_nxt [CH_NUM];
    logic [HIST_W-1:0] ptr_r [CH_NUM];
    logic [HIST_W-1:0] ptr_nxt [CH_NUM];
    logic [CNT_W-1:0] cnt_r [CH_NUM];
    logic [CNT_W-1:0] cnt_nxt [CH_NUM];

    // History memory ports
    logic mem_we;
    logic [MEM_AW-1:0] mem_waddr, mem_raddr;
    logic [WORD_W-1:0] mem_rdata;

    adc_hist_mem adc_hist_mem_inst
    (
        .mclk(mclk),
        .rst(rst),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(samp_r),
        .rd_addr(mem_raddr),
        .rd_data(mem_rdata)
    );

    // Scaling temporaries
    logic signed [WORD_W:0] raw_s, scl_s, lo_s, hi_s;
    logic [WORD_W-1:0] clamp_v;
    logic is_bip, is_valid, has_open;
    logic tick;
    logic signed [SUM_W-1:0] sum_new, old_s;
    logic [CNT_W-1:0] cnt_new;
    logic [CH_W-1:0] widx;
    logic [WORD_W-1:0] out_v;

    assign tick = (tick_r == '0);
    assign mem_raddr = {ch_r, ptr_r[ch_r]};
    assign mem_waddr = {ch_r, ptr_r[ch_r]};
    assign mem_we = (state_r == ST_HIST);

    // Scale and clamp the converter reading for the current range
    always_comb
    begin
        raw_s = signed'({conv_raw[WORD_W-1], conv_raw});
        is_bip = (rng_r == RNG_VPM10);
        is_valid = (rng_r == RNG_V0_5) || (rng_r == RNG_V1_5) || (rng_r == RNG_V0_10)
                   || is_bip || (rng_r == RNG_I4_20) || (rng_r == RNG_I0_20);
        has_open = (rng_r == RNG_V1_5) || (rng_r == RNG_I4_20);
        if (is_bip)
        begin
            scl_s = raw_s - signed'({1'b0, BIP_OFS});
            lo_s = signed'({BIP_MIN[WORD_W-1], BIP_MIN});
            hi_s = signed'({BIP_MAX[WORD_W-1], BIP_MAX});
        end
        else
        begin
            scl_s = raw_s + signed'({1'b0, UNI_LO});
            lo_s = signed'({UNI_MIN[WORD_W-1], UNI_MIN});
            hi_s = signed'({UNI_MAX[WORD_W-1], UNI_MAX});
        end
        if (scl_s < lo_s)
            clamp_v = lo_s[WORD_W-1:0];
        else if (scl_s > hi_s)
            clamp_v = hi_s[WORD_W-1:0];
        else
            clamp_v = scl_s[WORD_W-1:0];
    end

    // Sequencer, averaging and result words
    always_comb
    begin
        state_nxt = state_r;
        tick_nxt = tick ? TICK_W'(POINT_CYC_P - 1) : tick_r - 1'b1;
        ch_nxt = ch_r;
        start_nxt = 1'b0;
        rng_nxt = rng_r;
        samp_nxt = samp_r;
        open_nxt = open_r;
        bad_nxt = bad_r;
        word_nxt = word_r;
        valid_nxt = valid_r;
        upd_nxt = 1'b0;
        idx_nxt = idx_r;
        four_nxt = sw_r[SW_FOUR];
        sum_nxt = sum_r;
        ptr_nxt = ptr_r;
        cnt_nxt = cnt_r;
        old_s = (cnt_r[ch_r] == CNT_FULL) ? SUM_W'(signed'(mem_rdata)) : '0;
        sum_new = sum_r[ch_r] + SUM_W'(signed'(samp_r)) - old_s;
        cnt_new = (cnt_r[ch_r] == CNT_FULL) ? CNT_FULL : cnt_r[ch_r] + 1'b1;
        widx = four_r ? (ch_r >> 1) : ch_r;
        if (sw_r[SW_AVG])
            out_v = sum_new[AVG_SHIFT +: WORD_W];
        else
            out_v = samp_r;
        if (open_r)
            out_v = OPEN_CODE;
        if (four_r)
            valid_nxt[CH_NUM-1:CH_NUM/2] = '0;
        unique case (state_r)
            ST_WAIT:
            begin
                if (tick)
                begin
                    start_nxt = 1'b1;
                    rng_nxt = rng_sel[ch_r];
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (conv_done)
                begin
                    bad_nxt = !is_valid;
                    samp_nxt = is_valid ? clamp_v : ZERO_CODE;
                    open_nxt = is_valid && has_open
                               && (raw_s < signed'({OPEN_THR[WORD_W-1], OPEN_THR}));
                    state_nxt = ST_HIST;
                end
                else if (tick)
                    state_nxt = ST_WAIT;
            end
            ST_HIST:
            begin
                sum_nxt[ch_r] = sum_new;
                ptr_nxt[ch_r] = ptr_r[ch_r] + 1'b1;
                cnt_nxt[ch_r] = cnt_new;
                if (!sw_r[SW_AVG] || open_r || (cnt_new == CNT_FULL))
                begin
                    word_nxt[widx*WORD_W +: WORD_W] = out_v;
                    valid_nxt[widx] = 1'b1;
                    upd_nxt = 1'b1;
                    idx_nxt = widx;
                end
                if (four_r)
                    ch_nxt = {ch_r[CH_W-1:1] + 1'b1, 1'b0};
                else
                    ch_nxt = ch_r + 1'b1;
                state_nxt = ST_WAIT;
            end
            default:
                state_nxt = ST_WAIT;
        endcase
        if (four_r != sw_r[SW_FOUR])
        begin
            ch_nxt = '0;
            state_nxt = ST_WAIT;
            start_nxt = 1'b0; // No start whose answer would be dropped
            rng_nxt = rng_r;
        end
    end

    // Register the sequencer and results
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_r <= ST_WAIT;
            tick_r <= '0;
            ch_r <= '0;
            start_r <= 1'b0;
            rng_r <= RNG_V0_5;
            samp_r <= ZERO_CODE;
            open_r <= 1'b0;
            bad_r <= 1'b0;
            word_r <= '0;
            valid_r <= '0;
            upd_r <= 1'b0;
            idx_r <= '0;
            four_r <= 1'b0;
            for (int i = 0; i < CH_NUM; i++)
            begin
                sum_r[i] <= '0;
                ptr_r[i] <= '0;
                cnt_r[i] <= '0;
            end
        end
        else
        begin
            state_r <= state_nxt;
            tick_r <= tick_nxt;
            ch_r <= ch_nxt;
            start_r <= start_nxt;
            rng_r <= rng_nxt;
            samp_r <= samp_nxt;
            open_r <= open_nxt;
            bad_r <= bad_nxt;
            word_r <= word_nxt;
            valid_r <= valid_nxt;
            upd_r <= upd_nxt;
            idx_r <= idx_nxt;
            four_r <= four_nxt;
            sum_r <= sum_nxt;
            ptr_r <= ptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign conv_start = start_r;
    assign conv_ch = ch_r;
    assign conv_rng = rng_r;
    assign res_word = word_r;
    assign res_valid = valid_r;
    assign res_upd = upd_r;
    assign res_idx = idx_r;
    assign four_mode = four_r;
    assign range_bad = bad_r;

endmodule
`default_nettype wire

// >>> hw/adc_hist_mem.sv
// Purpose: Sample history memory for the moving mean, eight samples per input
// Assumes: One write and one read port on the module clock
// Notes:   Read data come out of a register one clock after the address
`timescale 1ns/100ps
`default_nettype none
module adc_hist_mem
    import adc_pkg::*;
(
    input wire logic mclk, // Module clock
    input wire logic rst, // Synchronous reset, high
    input wire logic wr_en, // Write strobe
    input wire logic [adc_pkg::MEM_AW-1:0] wr_addr, // Write address
    input wire logic [adc_pkg::WORD_W-1:0] wr_data, // Write data
    input wire logic [adc_pkg::MEM_AW-1:0] rd_addr, // Read address
    output logic [adc_pkg::WORD_W-1:0] rd_data // Registered read data
);
    import adc_pkg::*;

    logic [WORD_W-1:0] mem [CH_NUM*HIST_DEPTH];
    logic [WORD_W-1:0] rd_data_r;
    logic [WORD_W-1:0] rd_data_nxt;

    // Read path
    always_comb
    begin
        rd_data_nxt = mem[rd_addr];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            rd_data_r <= ZERO_CODE;
        else
            rd_data_r <= rd_data_nxt;
    end

    // Write path, array holds no reset
    always_ff @(posedge mclk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    assign rd_data = rd_data_r;

endmodule
`default_nettype wire

// >>> hw/adc_pkg.sv
// Purpose: Shared constants and types for the eight-input converter control block
// Assumes: One module clock at 10 MHz; converter reports readings in span units
// Notes:   Span units put the range low end at 0 and the high end at 6000
package adc_pkg;

    // Channel and width figures
    localparam int CH_NUM = 8;
    localparam int CH_W = 3;
    localparam int WORD_W = 16;
    localparam int RNG_W = 3;
    localparam int HIST_DEPTH = 8;
    localparam int HIST_W = 3;
    localparam int MEM_AW = 6;
    localparam int SUM_W = 19;
    localparam int CNT_W = 4;
    localparam int AVG_SHIFT = 3;
    localparam int SW_NUM = 15;
    localparam int TICK_W = 14;

    // Switch positions in the synchronised switch vector
    localparam int SW_RANGE_BITS = 12;
    localparam int SW_AVG = 12;
    localparam int SW_FOUR = 13;
    localparam int SW_SOFT = 14;

    // Range codes, bit 0 is the first switch of a group
    localparam logic [2:0] RNG_V0_5 = 3'h0;
    localparam logic [2:0] RNG_V1_5 = 3'h1;
    localparam logic [2:0] RNG_V0_10 = 3'h2;
    localparam logic [2:0] RNG_VPM10 = 3'h3;
    localparam logic [2:0] RNG_I4_20 = 3'h4;
    localparam logic [2:0] RNG_I0_20 = 3'h5;

    // Output codes and limits
    localparam logic [15:0] BIP_OFS = 16'h0BB8;
    localparam logic [15:0] BIP_MIN = 16'hF31C;
    localparam logic [15:0] BIP_MAX = 16'h0CE4;
    localparam logic [15:0] UNI_LO = 16'h0000;
    localparam logic [15:0] UNI_HI = 16'h1770;
    localparam logic [15:0] UNI_MIN = 16'hFED4;
    localparam logic [15:0] UNI_MAX = 16'h189C;
    localparam logic [15:0] OPEN_THR = 16'hFED4;
    localparam logic [15:0] OPEN_CODE = 16'h7FFF;
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;

    // Timing: one point per millisecond
    localparam int POINT_TIME_US = 1000;
    localparam int CLK_MHZ = 10;
    localparam int POINT_CYC = POINT_TIME_US * CLK_MHZ;

    // Sequencer states
    typedef enum logic [2:0]
    {
        ST_WAIT = 3'b001,
        ST_CONV = 3'b010,
        ST_HIST = 3'b100
    } adc_state_type;

endpackage

// >>> test/adc_conv_model.sv
// Purpose: Converter model answering each start once
// Assumes: Reply delay shorter than one slot
// Notes: Reading bus is scrambled outside the strobe cycle
`timescale 1ns/100ps
`default_nettype none
module adc_conv_model
(
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic conv_start, // Start pulse
    input wire logic [2:0] conv_ch, // Input picked
    input wire logic [127:0] raw_tab, // Reading per input
    input wire logic [3:0] dly, // Reply delay
    output logic conv_done, // Result strobe
    output logic [15:0] conv_raw // Reading
);
    logic [3:0] cnt_r;
    logic busy_r;
    logic [2:0] ch_r;
    // Count down the delay, then strobe the reading of the latched input
    always_ff @(posedge mclk)
    begin
        conv_done <= 1'b0;
        conv_raw <= rst ? 16'h0000 : ~conv_raw;
        if (rst)
            busy_r <= 1'b0;
        else if (conv_start)
        begin
            busy_r <= 1'b1;
            cnt_r <= dly;
            ch_r <= conv_ch;
        end
        else if (busy_r && cnt_r == 4'h0)
        begin
            busy_r <= 1'b0;
            conv_done <= 1'b1;
            conv_raw <= raw_tab[16*ch_r +: 16];
        end
        else
            cnt_r <= cnt_r - 4'h1;
    end
endmodule
`default_nettype wire

// >>> test/adc_ctrl_sva.sv
// Purpose: Port checker for the converter control block
// Assumes: Bound to every adc_ctrl instance
// Notes: Slot length follows the design parameter
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_sva
    import adc_pkg::*;
#(
    parameter int unsigned POINT_CYC_P = adc_pkg::POINT_CYC
)
(
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic conv_done, // Result strobe
    input wire logic conv_start, // Start pulse
    input wire logic [adc_pkg::CH_W-1:0] conv_ch, // Input converted
    input wire logic [adc_pkg::RNG_W-1:0] conv_rng, // Its range
    input wire logic [adc_pkg::CH_NUM*adc_pkg::WORD_W-1:0] res_word, // Words
    input wire logic [adc_pkg::CH_NUM-1:0] res_valid, // Word valid
    input wire logic res_upd, // Update pulse
    input wire logic [adc_pkg::CH_W-1:0] res_idx, // Word updated
    input wire logic four_mode, // Four-input mode
    input wire logic range_bad // Invalid code seen
);
    logic [15:0] gap_r;
    logic [15:0] gap_nxt;
    logic seen_r;
    logic seen_nxt;
    logic four_r;
    logic [15:0] upd_w;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Word just written
    assign upd_w = res_word[16*res_idx +: 16];
    // Cycles since last start, forgotten on a mode change
    always_comb
    begin
        gap_nxt = conv_start ? 16'h0001 : gap_r + 16'h0001;
        seen_nxt = conv_start | (seen_r & (four_mode == four_r));
    end
    // Helper registers
    always_ff @(posedge mclk)
    begin
        gap_r <= rst ? 16'h0000 : gap_nxt;
        seen_r <= rst ? 1'b0 : seen_nxt;
        four_r <= four_mode;
    end
    sequence s_pulse;
        conv_start ##1 !conv_start;
    endsequence
    a_slot_period:
        assert property (conv_start && seen_r |-> gap_r == POINT_CYC_P) else $error("bad slot");
    a_start_pulse:
        assert property (conv_start |-> s_pulse) else $error("start not a pulse");
    a_answer_lag:
        assert property (res_upd |-> $past(conv_done, 2)) else $error("update lag");
    a_word_only_upd:
        assert property ($changed(res_word) |-> res_upd) else $error("word change no pulse");
    a_idx_map:
        assert property (res_upd |-> res_idx == ($past(four_mode) ? $past(conv_ch) >> 1
            : $past(conv_ch)))
        else $error("wrong word index");
    a_valid_set:
        assert property (res_upd |-> res_valid[res_idx]) else $error("valid not set");
    a_even_only:
        assert property (four_mode && conv_start |-> !conv_ch[0]) else $error("odd input");
    a_four_words:
        assert property (four_mode [*3] |-> res_valid[7:4] == 4'h0) else $error("upper word");
    a_bip_clamp:
        assert property (res_upd && conv_rng == RNG_VPM10 |-> $signed(upd_w) >= -3300
            && $signed(upd_w) <= 3300) else $error("bipolar clamp");
    a_uni_clamp:
        assert property (res_upd && conv_rng inside {3'h0, 3'h2, 3'h5} |->
            $signed(upd_w) >= -300 && $signed(upd_w) <= 6300) else $error("unipolar clamp");
    a_bad_zero:
        assert property (res_upd && range_bad |-> upd_w == ZERO_CODE) else $error("bad code");
endmodule
bind adc_ctrl adc_ctrl_sva #(.POINT_CYC_P(POINT_CYC_P)) adc_ctrl_sva_inst (.mclk(mclk),
    .rst(rst), .conv_done(conv_done), .conv_start(conv_start), .conv_ch(conv_ch),
    .conv_rng(conv_rng), .res_word(res_word), .res_valid(res_valid), .res_upd(res_upd),
    .res_idx(res_idx), .four_mode(four_mode), .range_bad(range_bad));
`default_nettype wire

// >>> test/adc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Short slot of 20 cycles
// Notes: Inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module adc_ctrl_tb_top;
    import adc_pkg::*;
    localparam int P = 20;
    localparam int RND = 8 * P + 8;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] range_sw = 12'h000;
    logic avg_sw = 1'b0;
    logic four_sw = 1'b0;
    logic soft_en_sw = 1'b0;
    logic [23:0] soft_range = 24'h000000;
    logic [127:0] raw_tab = '0;
    logic [3:0] dly = 4'h1;
    logic conv_done;
    logic [15:0] conv_raw;
    logic conv_start;
    logic [2:0] conv_ch;
    logic [2:0] conv_rng;
    logic [127:0] res_word;
    logic [7:0] res_valid;
    logic four_mode;
    logic range_bad;
    int n_fail = 0;
    int tests_run = 0;
    int n;
    adc_ctrl #(.POINT_CYC_P(P)) adc_ctrl_inst (.mclk(mclk), .rst(rst), .range_sw(range_sw),
        .avg_sw(avg_sw), .four_sw(four_sw), .soft_en_sw(soft_en_sw), .soft_range(soft_range),
        .conv_done(conv_done), .conv_raw(conv_raw), .conv_start(conv_start), .conv_ch(conv_ch),
        .conv_rng(conv_rng), .res_word(res_word), .res_valid(res_valid), .res_upd(),
        .res_idx(), .four_mode(four_mode), .range_bad(range_bad));
    adc_conv_model adc_conv_model_inst (.mclk(mclk), .rst(rst), .conv_start(conv_start),
        .conv_ch(conv_ch), .raw_tab(raw_tab), .dly(dly), .conv_done(conv_done),
        .conv_raw(conv_raw));
    // Clock
    always #50 mclk = ~mclk;
    task automatic cycles(input int c);
        repeat (c) @(negedge mclk);
    endtask
    task automatic chk_all(input logic [127:0] e, input logic [7:0] v);
        for (int k = 0; k < 8; k++)
            if (v[k])
                `CHK("res_word", e[16*k +: 16], res_word[16*k +: 16])
        `CHK("res_valid", v, res_valid)
    endtask
    task automatic wait_ch0;
        n = 0;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (!(conv_start === 1'b1 && conv_ch === 3'h0) && n < 400);
        `CHK("ch0 start", 1'b1, conv_start)
    endtask
    task automatic t_switch;
        range_sw = {RNG_I4_20, RNG_VPM10, RNG_V1_5, RNG_V0_5};
        raw_tab = {16'h1770, 16'hFED3, 16'h1B58, 16'hEC78, 16'hFF06, 16'hFE70, 16'h0BB8, 16'h1964};
        cycles(2 * RND);
        chk_all({16'h1770, 16'h7FFF, 16'h0CE4, 16'hF31C, 16'hFF06, 16'h7FFF, 16'h0BB8,
            16'h189C}, 8'hFF);
        raw_tab = {16'h1770, 16'h01F4, 16'h0BB8, 16'h0000, 16'hFF06, 16'h0064, 16'h0BB8, 16'h1964};
        cycles(RND);
        chk_all({16'h1770, 16'h01F4, 16'h0000, 16'hF448, 16'hFF06, 16'h0064, 16'h0BB8,
            16'h189C}, 8'hFF);
        $display("t_switch done");
    endtask
    task automatic t_soft;
        soft_en_sw = 1'b1;
        soft_range = {3'h7, 3'h6, 3'h5, 3'h4, 3'h1, 3'h0, 3'h2, 3'h3};
        raw_tab = {8{16'h03E8}};
        cycles(2 * RND);
        chk_all({16'h0000, 16'h0000, {5{16'h03E8}}, 16'hF830}, 8'hFF);
        wait_ch0;
        `CHK("conv_rng", RNG_VPM10, conv_rng)
        `CHK("range_bad", 1'b1, range_bad)
        soft_en_sw = 1'b0;
        $display("t_soft done");
    endtask
    task automatic t_four;
        range_sw = 12'h000;
        four_sw = 1'b1;
        raw_tab = {16'h8, 16'h7, 16'h6, 16'h5, 16'h4, 16'h3, 16'h2, 16'h1};
        cycles(2 * RND);
        `CHK("four_mode", 1'b1, four_mode)
        chk_all({64'h0, 16'h7, 16'h5, 16'h3, 16'h1}, 8'h0F);
        wait_ch0;
        wait_ch0;
        `CHK("four period", 4 * P, n)
        four_sw = 1'b0;
        $display("t_four done");
    endtask
    task automatic t_avg;
        avg_sw = 1'b1;
        dly = 4'hA;
        raw_tab = '0;
        rst = 1'b1;
        cycles(10);
        rst = 1'b0;
        wait_ch0;
        for (int r = 1; r < 10; r++)
        begin
            wait_ch0;
            `CHK("eight period", 8 * P, n)
            raw_tab = {8{16'(100 * r)}};
            if (r == 7)
                `CHK("held words", 8'h00, res_valid)
            if (r == 8)
                chk_all({8{16'h015E}}, 8'hFF);
            if (r == 9)
                chk_all({8{16'h01C2}}, 8'hFF);
        end
        $display("t_avg done");
    endtask
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        cycles(10);
        rst = 1'b0;
        cycles(3);
        chk_all('0, 8'h00);
        t_switch;
        t_soft;
        t_four;
        t_avg;
        final_report;
    end
    // Watchdog
    initial
    begin
        #1000000;
        n_fail++;
        final_report;
    end
endmodule
`default_nettype wire
